// ==== sbte_pkg.sv ====
// Constants, register map and carrier types of the serial byte engine.
// Assumes a single 25 MHz clock shared by all files.
`default_nettype none
package sbte_pkg;
	// Clock and serial line timing
	localparam int CLK_HZ = 25000000;
	localparam int BAUD_BPS = 38400;
	localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
	localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
	localparam int DATA_BITS = 8;
	localparam int XFER_COUNT = 256;
	// Register indices on the plain port
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_TX_SRC = 4'h1;
	localparam logic [3:0] ADDR_TX_CNT = 4'h2;
	localparam logic [3:0] ADDR_RX_DST = 4'h3;
	localparam logic [3:0] ADDR_RX_CNT = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h5;
	localparam logic [3:0] ADDR_CLEAR = 4'h6;
	localparam logic [3:0] ADDR_ENABLE = 4'h7;
	localparam logic [3:0] ADDR_BUF_PTR = 4'h8;
	localparam logic [3:0] ADDR_BUF_DATA = 4'h9;
	// Control bits
	localparam int CTRL_TX_EN = 0;
	localparam int CTRL_RX_EN = 1;
	// Status, clear and enable bit positions
	localparam int ST_TX_DONE = 0;
	localparam int ST_RX_DONE = 1;
	localparam int ST_RX_ERR = 2;
	localparam int ST_RXI = 3;
	localparam int ST_TXI = 4;
	localparam int ST_TEI = 5;
	localparam int ST_W = 6;
	// Buffer areas in the shared RAM
	localparam logic [8:0] TX_BASE = 9'h000;
	localparam logic [8:0] RX_BASE = 9'h100;
	localparam logic [7:0] INIT_LAST = 8'hff;
	// RAM access request
	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] wdata;
		logic wr;
	} sbte_mem_req_t;
	// Received byte with its qualifiers
	typedef struct packed {
		logic [7:0] data;
		logic valid;
		logic frame_err;
	} sbte_rx_byte_t;
endpackage
`default_nettype wire

// ==== sbte_mem.sv ====
// Single-port byte RAM holding the transmit and receive buffers.
// Assumes one request per cycle; read data are registered.
`timescale 1ns/1ps
`default_nettype none
module sbte_mem #(
	parameter int AW = 9,
	parameter int DW = 8
) (
	input wire logic clk_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic wr_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] store [0:(1<<AW)-1];

	// Write on strobe, read every cycle
	always_ff @(posedge clk_i) begin
		if (wr_i) begin
			store[addr_i] <= wdata_i;
		end
		rdata_o <= store[addr_i];
	end
endmodule
`default_nettype wire

// ==== sbte_rx.sv ====
// Asynchronous receiver: 8 data bits, no parity, one stop bit.
// Assumes the line input is already synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module sbte_rx #(
	parameter int BIT_CYC = sbte_pkg::BIT_CYCLES,
	parameter int HALF_CYC = sbte_pkg::HALF_BIT_CYCLES
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic rxd_i,
	input wire logic en_i,
	output sbte_pkg::sbte_rx_byte_t rx_o
);
	typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} sbte_rx_st_t;
	sbte_rx_st_t st;
	logic [9:0] cnt;
	logic [2:0] idx;
	logic [7:0] rx_shift_reg;

	// Bit timing, shifting and hand-off of the finished byte
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= R_IDLE;
			cnt <= 10'h0;
			idx <= 3'h0;
			rx_shift_reg <= 8'h0;
			rx_o <= '0;
		end else begin
			rx_o.valid <= 1'b0;
			rx_o.frame_err <= 1'b0;
			case (st)
			R_IDLE: begin
				cnt <= 10'h0;
				if (en_i && !rxd_i) begin
					st <= R_START;
				end
			end
			R_START: begin
				if (cnt == 10'(HALF_CYC - 1)) begin
					cnt <= 10'h0;
					idx <= 3'h0;
					st <= rxd_i ? R_IDLE : R_DATA; // Glitch rejects
				end else begin
					cnt <= cnt + 10'h1;
				end
			end
			R_DATA: begin
				if (cnt == 10'(BIT_CYC - 1)) begin
					cnt <= 10'h0;
					rx_shift_reg <= {rxd_i, rx_shift_reg[7:1]};
					idx <= idx + 3'h1;
					if (idx == 3'(sbte_pkg::DATA_BITS - 1)) begin
						st <= R_STOP;
					end
				end else begin
					cnt <= cnt + 10'h1;
				end
			end
			default: begin
				if (cnt == 10'(BIT_CYC - 1)) begin
					st <= R_IDLE;
					rx_o.data <= rx_shift_reg;
					rx_o.valid <= rxd_i;
					rx_o.frame_err <= !rxd_i;
				end else begin
					cnt <= cnt + 10'h1;
				end
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== sbte_engine.sv ====
// Serial byte transfer engine: request-driven RAM to serial copier.
// Assumes a plain register port master and one 25 MHz clock.
//
// Summary of operation
// - Transmit empty request copies RAM byte out
// - Receive full request copies byte to RAM
// - Byte transfers, count 256, ascending pattern
// - Transmit source address steps by one
// - Transmit destination fixed on data register
// - Receive source fixed on data register
// - Receive destination address steps by one
// - Interrupt after programmed count completes
// - Frame: eight data, no parity, one stop
// - Line runs at 38400 bits per second
// - Data register moves to shifter automatically
// - Finished byte moves to data register
// - Four serial interrupt sources offered
// - Flag clears at start; early repeats lost
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module sbte_engine #(
	parameter int COUNT = sbte_pkg::XFER_COUNT,
	parameter int BIT_CYC = sbte_pkg::BIT_CYCLES
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic rxd_i,
	output logic txd_o,
	output logic irq_o
);
	typedef enum logic [2:0] {
		S_INIT, S_IDLE, S_TX_RD, S_TX_WR, S_RX_WR
	} sbte_state_t;

	sbte_state_t st;
	logic [8:0] tx_cnt, rx_cnt, buf_ptr;
	logic [7:0] tx_src, rx_dst, init_idx;
	logic tx_en, rx_en;
	logic [5:0] status, irq_en, evts, clr_mask;
	logic tx_request_flag, rx_request_flag;
	logic [7:0] tx_data_reg, rx_data_reg, mem_q;
	logic tdr_full, tdr_empty_q, tx_busy;
	logic [9:0] tx_shift_reg, tx_baud;
	logic [3:0] tx_bit;
	logic tx_load, txi_evt, tei_evt, rxi_evt, err_evt;
	logic go_tx, go_rx, sw_buf, buf_rd_q, tx_done_evt, rx_done_evt;
	logic [15:0] rdata_q;
	sbte_pkg::sbte_mem_req_t eng_req, mem_req;
	sbte_pkg::sbte_rx_byte_t rx_byte;

	// Write strobe aimed at one register
	function automatic logic is_wr(input logic [3:0] a);
		return wr_i && (addr_i == a);
	endfunction

	// RAM address inside one buffer area
	function automatic logic [8:0] area(input logic [8:0] base,
		input logic [7:0] off);
		return base | {1'b0, off};
	endfunction

	// Software buffer access takes the RAM and stalls the engine
	assign sw_buf = (wr_i || rd_i) && (addr_i == sbte_pkg::ADDR_BUF_DATA);
	assign go_rx = rx_request_flag && (rx_cnt != 9'h0) && rx_en;
	assign go_tx = !go_rx && tx_request_flag && (tx_cnt != 9'h0) &&
		tx_en && !tdr_full;

	// Engine RAM request per state
	always_comb begin
		eng_req = '0;
		case (st)
		S_INIT: begin
			eng_req.addr = area(sbte_pkg::TX_BASE, init_idx);
			eng_req.wdata = init_idx;
			eng_req.wr = 1'b1;
		end
		S_TX_RD: begin
			eng_req.addr = area(sbte_pkg::TX_BASE, tx_src);
		end
		S_RX_WR: begin
			eng_req.addr = area(sbte_pkg::RX_BASE, rx_dst);
			eng_req.wdata = rx_data_reg;
			eng_req.wr = 1'b1;
		end
		default: begin
			eng_req = '0;
		end
		endcase
	end

	// RAM port mux, software first
	always_comb begin
		mem_req = eng_req;
		if (sw_buf) begin
			mem_req.addr = buf_ptr;
			mem_req.wdata = wdata_i[7:0];
			mem_req.wr = wr_i;
		end
	end

	sbte_mem #(
		.AW(9),
		.DW(8)
	) u_mem (
		.clk_i(clk_i),
		.addr_i(mem_req.addr),
		.wdata_i(mem_req.wdata),
		.wr_i(mem_req.wr),
		.rdata_o(mem_q)
	);

	// Transfer sequencer
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= S_INIT;
		end else begin
			case (st)
			S_INIT: begin
				if (!sw_buf && init_idx == sbte_pkg::INIT_LAST) begin
					st <= S_IDLE;
				end
			end
			S_IDLE: begin
				if (go_rx) begin
					st <= S_RX_WR;
				end else if (go_tx) begin
					st <= S_TX_RD;
				end
			end
			S_TX_RD: begin
				if (!sw_buf) begin
					st <= S_TX_WR;
				end
			end
			S_TX_WR: begin
				st <= S_IDLE;
			end
			default: begin
				if (!sw_buf) begin
					st <= S_IDLE;
				end
			end
			endcase
		end
	end

	// Pattern fill index after reset
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			init_idx <= 8'h0;
		end else if (st == S_INIT && !sw_buf) begin
			init_idx <= init_idx + 8'h1;
		end
	end

	// Addresses and counts, software reload over engine update
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tx_src <= 8'h0;
			rx_dst <= 8'h0;
			tx_cnt <= 9'(COUNT);
			rx_cnt <= 9'(COUNT);
		end else begin
			if (is_wr(sbte_pkg::ADDR_TX_SRC)) begin
				tx_src <= wdata_i[7:0];
			end else if (st == S_TX_WR) begin
				tx_src <= tx_src + 8'h1;
			end
			if (is_wr(sbte_pkg::ADDR_TX_CNT)) begin
				tx_cnt <= wdata_i[8:0];
			end else if (st == S_TX_WR) begin
				tx_cnt <= tx_cnt - 9'h1;
			end
			if (is_wr(sbte_pkg::ADDR_RX_DST)) begin
				rx_dst <= wdata_i[7:0];
			end else if (st == S_RX_WR && !sw_buf) begin
				rx_dst <= rx_dst + 8'h1;
			end
			if (is_wr(sbte_pkg::ADDR_RX_CNT)) begin
				rx_cnt <= wdata_i[8:0];
			end else if (st == S_RX_WR && !sw_buf) begin
				rx_cnt <= rx_cnt - 9'h1;
			end
		end
	end

	// flag clears at start, repeats lost
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tx_request_flag <= 1'b0;
			rx_request_flag <= 1'b0;
		end else begin
			if (!tx_en || (st == S_IDLE && go_tx)) begin
				tx_request_flag <= 1'b0;
			end else if (txi_evt) begin
				tx_request_flag <= 1'b1;
			end
			if (!rx_en || (st == S_IDLE && go_rx)) begin
				rx_request_flag <= 1'b0;
			end else if (rxi_evt) begin
				rx_request_flag <= 1'b1;
			end
		end
	end

	assign tx_load = tdr_full && !tx_busy && tx_en;
	assign txi_evt = tx_en && !tdr_full && !tdr_empty_q;
	assign tei_evt = tx_busy && tx_baud == 10'(BIT_CYC - 1) &&
		tx_bit == 4'h9 && !tdr_full;

	// Transmit data register, shifter and bit timing
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tx_data_reg <= 8'h0;
			tdr_full <= 1'b0;
			tdr_empty_q <= 1'b0;
			tx_shift_reg <= 10'h3ff;
			tx_busy <= 1'b0;
			tx_bit <= 4'h0;
			tx_baud <= 10'h0;
		end else begin
			tdr_empty_q <= tx_en && !tdr_full;
			if (st == S_TX_WR) begin
				tx_data_reg <= mem_q;
				tdr_full <= 1'b1;
			end else if (tx_load) begin
				tdr_full <= 1'b0;
			end
			if (tx_load) begin
				tx_shift_reg <= {1'b1, tx_data_reg, 1'b0};
				tx_busy <= 1'b1;
				tx_bit <= 4'h0;
				tx_baud <= 10'h0;
			end else if (tx_busy) begin
				if (tx_baud == 10'(BIT_CYC - 1)) begin
					tx_baud <= 10'h0;
					tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
					if (tx_bit == 4'h9) begin
						tx_busy <= 1'b0;
					end else begin
						tx_bit <= tx_bit + 4'h1;
					end
				end else begin
					tx_baud <= tx_baud + 10'h1;
				end
			end
		end
	end
	assign txd_o = tx_shift_reg[0];

	sbte_rx #(
		.BIT_CYC(BIT_CYC),
		.HALF_CYC(BIT_CYC / 2)
	) u_rx (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.rxd_i(rxd_i),
		.en_i(rx_en),
		.rx_o(rx_byte)
	);

	// Receive data register holds the last byte
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rx_data_reg <= 8'h0;
		end else if (rx_byte.valid) begin
			rx_data_reg <= rx_byte.data;
		end
	end

	assign rxi_evt = rx_byte.valid;
	assign err_evt = rx_byte.frame_err || (rx_byte.valid && rx_request_flag);
	assign tx_done_evt = st == S_TX_WR && tx_cnt == 9'h1;
	assign rx_done_evt = st == S_RX_WR && !sw_buf && rx_cnt == 9'h1;
	assign evts = {tei_evt, txi_evt, rxi_evt, err_evt, rx_done_evt,
		tx_done_evt};
	// Strobe named directly so the mask follows the bus every cycle
	assign clr_mask = (wr_i && addr_i == sbte_pkg::ADDR_CLEAR) ?
		wdata_i[5:0] : 6'h0;

	// Sticky status, set beats clear; control registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			status <= 6'h0;
			irq_en <= 6'h0;
			tx_en <= 1'b0;
			rx_en <= 1'b0;
			buf_ptr <= 9'h0;
		end else begin
			status <= (status & ~clr_mask) | evts;
			if (is_wr(sbte_pkg::ADDR_ENABLE)) begin
				irq_en <= wdata_i[5:0];
			end
			if (is_wr(sbte_pkg::ADDR_CTRL)) begin
				tx_en <= wdata_i[sbte_pkg::CTRL_TX_EN];
				rx_en <= wdata_i[sbte_pkg::CTRL_RX_EN];
			end
			if (is_wr(sbte_pkg::ADDR_BUF_PTR)) begin
				buf_ptr <= wdata_i[8:0];
			end else if (sw_buf) begin
				buf_ptr <= buf_ptr + 9'h1;
			end
		end
	end
	assign irq_o = |(status & irq_en);

	// Registered read data, zero outside the answer cycle
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdata_q <= 16'h0;
			buf_rd_q <= 1'b0;
		end else begin
			buf_rd_q <= rd_i && addr_i == sbte_pkg::ADDR_BUF_DATA;
			rdata_q <= 16'h0;
			if (rd_i) begin
				if (addr_i == sbte_pkg::ADDR_CTRL) begin
					rdata_q <= {14'h0, rx_en, tx_en};
				end else if (addr_i == sbte_pkg::ADDR_TX_SRC) begin
					rdata_q <= {8'h0, tx_src};
				end else if (addr_i == sbte_pkg::ADDR_TX_CNT) begin
					rdata_q <= {7'h0, tx_cnt};
				end else if (addr_i == sbte_pkg::ADDR_RX_DST) begin
					rdata_q <= {8'h0, rx_dst};
				end else if (addr_i == sbte_pkg::ADDR_RX_CNT) begin
					rdata_q <= {7'h0, rx_cnt};
				end else if (addr_i == sbte_pkg::ADDR_STATUS) begin
					rdata_q <= {10'h0, status};
				end else if (addr_i == sbte_pkg::ADDR_ENABLE) begin
					rdata_q <= {10'h0, irq_en};
				end else if (addr_i == sbte_pkg::ADDR_BUF_PTR) begin
					rdata_q <= {7'h0, buf_ptr};
				end
			end
		end
	end
	assign rdata_o = buf_rd_q ? {8'h0, mem_q} : rdata_q;

	// Checks on the transfer paths
	a_tx_read_load: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(st == S_TX_RD && !sw_buf) |=> st == S_TX_WR ##1 tdr_full)
		else $error("transmit read did not load data register");
	a_rx_start_write: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(st == S_IDLE && go_rx) |=> st == S_RX_WR)
		else $error("receive request did not start a write");
	a_count_reset: assert property (
		@(posedge clk_i)
		$past(sys_rst_i) && !sys_rst_i |-> tx_cnt == 9'(COUNT) &&
		rx_cnt == 9'(COUNT) && st == S_INIT)
		else $error("counts not at default after reset");
	a_tx_src_step: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(st == S_TX_WR && !(wr_i && addr_i == sbte_pkg::ADDR_TX_SRC)) |=>
		tx_src == $past(tx_src) + 8'h1)
		else $error("transmit source did not step");
	a_tdr_only_engine: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		$changed(tx_data_reg) |-> $past(st) == S_TX_WR)
		else $error("data register written outside a transfer");
	a_rx_src_fixed: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(st == S_RX_WR && !sw_buf) |-> mem_req.wr &&
		mem_req.wdata == rx_data_reg)
		else $error("receive write not taken from data register");
	a_rx_dst_step: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(st == S_RX_WR && !sw_buf &&
		!(wr_i && addr_i == sbte_pkg::ADDR_RX_DST)) |=>
		rx_dst == $past(rx_dst) + 8'h1)
		else $error("receive destination did not step");
	a_done_irq: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(tx_done_evt && irq_en[sbte_pkg::ST_TX_DONE]) |=> irq_o)
		else $error("done did not raise interrupt");
	a_stop_high: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(tx_busy && tx_bit == 4'h9) |-> txd_o)
		else $error("stop bit not high");
	a_bit_period: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		tx_baud < 10'(BIT_CYC))
		else $error("bit timer past its period");
	a_tdr_to_shift: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		tx_load |=> tx_busy && !tdr_full && !txd_o)
		else $error("data register not moved to shifter");
	a_rx_request: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(rxi_evt && rx_en && !(st == S_IDLE && go_rx)) |=>
		rx_request_flag ##0 status[sbte_pkg::ST_RXI])
		else $error("received byte raised no request");
	a_source_sticky: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(evts != 6'h0) |=> (status & $past(evts)) == $past(evts))
		else $error("event not held in status");
	a_flag_clear: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(st == S_IDLE && go_tx) |=> !tx_request_flag)
		else $error("request flag not cleared at start");
	c_tx_byte: cover property (@(posedge clk_i) st == S_TX_WR);
	c_rx_byte: cover property (@(posedge clk_i) st == S_RX_WR);
	c_tx_done: cover property (@(posedge clk_i) tx_done_evt);
	c_rx_err: cover property (@(posedge clk_i) err_evt);
endmodule
`default_nettype wire

// ==== sbte_peer.sv ====
// Remote serial peer model: sends and collects 8N1 frames.
// Assumes BIT_CYC clocks of the engine clock per bit on both lines.
`timescale 1ns/1ps
`default_nettype none
module sbte_peer #(
	parameter int BIT_CYC = 8
) (
	input wire logic clk_i,
	input wire logic txd_i,
	output logic rxd_o
);
	logic [7:0] got_q[$];
	int frame_errs;

	initial begin
		rxd_o = 1'b1;
		frame_errs = 0;
	end

	// start, eight data LSB first, stop
	task automatic send_byte(input logic [7:0] d, input logic stop_ok);
		logic [9:0] f;
		f = {stop_ok, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			rxd_o <= f[i];
			repeat (BIT_CYC - 1) @(posedge clk_i);
		end
		@(posedge clk_i);
		rxd_o <= 1'b1;
		repeat (BIT_CYC) @(posedge clk_i);
	endtask

	initial begin : catch_frames
		logic [7:0] b;
		wait (txd_i === 1'b1);
		forever begin
			@(negedge txd_i);
			repeat (BIT_CYC / 2) @(posedge clk_i);
			if (txd_i !== 1'b0)
				frame_errs++;
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge clk_i);
				b[i] = txd_i;
			end
			repeat (BIT_CYC) @(posedge clk_i);
			if (txd_i !== 1'b1)
				frame_errs++;
			got_q.push_back(b);
		end
	end
endmodule
`default_nettype wire

// ==== sbte_engine_test.sv ====
// Self-checking bench for the serial byte transfer engine.
// Assumes short counts: COUNT 4 and 8 clocks per serial bit.
`timescale 1ns/1ps
`default_nettype none
module sbte_engine_test;
	localparam int CNT = 4;
	localparam int BIT = 8;
	logic clk_i, sys_rst_i, wr_i, rd_i, rxd_i, txd_o, irq_o;
	logic [3:0] addr_i;
	logic [15:0] wdata_i, rdata_o, d;
	int errors = 0;
	int num_checks = 0;
	logic [7:0] rx_pat[4] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};

	sbte_engine #(.COUNT(CNT), .BIT_CYC(BIT)) sbte_engine_inst (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.rxd_i(rxd_i), .txd_o(txd_o), .irq_o(irq_o));
	sbte_peer #(.BIT_CYC(BIT)) sbte_peer_inst (
		.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));

	// Clock of 40 ns
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	function automatic logic [15:0] bitv(input int p);
		return 16'h0001 << p;
	endfunction

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		// Let the write land before the caller looks at outputs
		#1;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask

	task automatic chk(input string name, input logic [15:0] e,
		input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic chk_reg(input string name, input logic [3:0] a,
		input logic [15:0] e);
		logic [15:0] v;
		rd(a, v);
		chk(name, e, v);
	endtask

	// Waits for n frames, then checks them as an ascending run
	task automatic chk_tx(input int n, input logic [7:0] first);
		for (int i = 0; i < 4000 && sbte_peer_inst.got_q.size() < n; i++)
			@(posedge clk_i);
		repeat (30 * BIT) @(posedge clk_i);
		chk("tx frames", 16'(n),
			16'(sbte_peer_inst.got_q.size()));
		chk("frame errors", 16'h0000,
			16'(sbte_peer_inst.frame_errs));
		for (int i = 0; i < n && sbte_peer_inst.got_q.size() > 0; i++)
			chk("tx byte", {8'h00, first + 8'(i)},
				{8'h00, sbte_peer_inst.got_q.pop_front()});
	endtask

	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog well beyond the expected few thousand cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		$display("unexpected watchdog expired");
		end_sim();
	end

	// Main sequence
	initial begin
		sys_rst_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 4'h0;
		wdata_i = 16'h0000;
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		// Reset values, write-only and unmapped places
		chk("irq reset", 16'h0000, {15'h0, irq_o});
		chk_reg("tx src", sbte_pkg::ADDR_TX_SRC, 16'h0000);
		chk_reg("tx cnt", sbte_pkg::ADDR_TX_CNT, 16'(CNT));
		chk_reg("rx dst", sbte_pkg::ADDR_RX_DST, 16'h0000);
		chk_reg("rx cnt", sbte_pkg::ADDR_RX_CNT, 16'(CNT));
		chk_reg("status", sbte_pkg::ADDR_STATUS, 16'h0000);
		chk_reg("enable", sbte_pkg::ADDR_ENABLE, 16'h0000);
		chk_reg("clear", sbte_pkg::ADDR_CLEAR, 16'h0000);
		wr(4'hf, 16'hffff);
		chk_reg("unmapped", 4'hf, 16'h0000);
		repeat (300) @(posedge clk_i);
		wr(sbte_pkg::ADDR_BUF_PTR, 16'h00fc);
		for (int i = 0; i < 4; i++)
			chk_reg("ram pattern", sbte_pkg::ADDR_BUF_DATA,
				16'h00fc + 16'(i));
		// Transmit a full count from the start of the buffer
		wr(sbte_pkg::ADDR_CTRL, bitv(sbte_pkg::CTRL_TX_EN));
		chk_tx(CNT, 8'h00);
		chk("irq masked", 16'h0000, {15'h0, irq_o});
		chk_reg("tx src", sbte_pkg::ADDR_TX_SRC, 16'(CNT));
		chk_reg("tx cnt", sbte_pkg::ADDR_TX_CNT, 16'h0000);
		wr(sbte_pkg::ADDR_ENABLE, bitv(sbte_pkg::ST_TX_DONE));
		chk("irq tx", 16'h0001, {15'h0, irq_o});
		wr(sbte_pkg::ADDR_CLEAR, bitv(sbte_pkg::ST_TX_DONE));
		chk("irq cleared", 16'h0000, {15'h0, irq_o});
		chk_reg("status", sbte_pkg::ADDR_STATUS, 16'h0030);
		// Reload across the top of the source range
		wr(sbte_pkg::ADDR_TX_SRC, 16'h00fe);
		wr(sbte_pkg::ADDR_TX_CNT, 16'h0002);
		chk_tx(2, 8'hfe);
		chk_reg("tx src wrap", sbte_pkg::ADDR_TX_SRC, 16'h0000);
		chk("irq tx again", 16'h0001, {15'h0, irq_o});
		// Receive a full count into the receive area
		wr(sbte_pkg::ADDR_CTRL, bitv(sbte_pkg::CTRL_RX_EN));
		wr(sbte_pkg::ADDR_ENABLE, bitv(sbte_pkg::ST_RX_DONE));
		for (int i = 0; i < 4; i++)
			sbte_peer_inst.send_byte(rx_pat[i], 1'b1);
		repeat (4 * BIT) @(posedge clk_i);
		chk("irq rx", 16'h0001, {15'h0, irq_o});
		chk_reg("rx dst", sbte_pkg::ADDR_RX_DST, 16'(CNT));
		chk_reg("rx cnt", sbte_pkg::ADDR_RX_CNT, 16'h0000);
		chk_reg("status", sbte_pkg::ADDR_STATUS, 16'h003b);
		wr(sbte_pkg::ADDR_BUF_PTR, 16'h0100);
		for (int i = 0; i < 4; i++)
			chk_reg("rx ram", sbte_pkg::ADDR_BUF_DATA,
				{8'h00, rx_pat[i]});
		// Broken stop bit stores nothing
		wr(sbte_pkg::ADDR_CLEAR, 16'h003f);
		sbte_peer_inst.send_byte(8'h77, 1'b0);
		repeat (4 * BIT) @(posedge clk_i);
		rd(sbte_pkg::ADDR_STATUS, d);
		chk("framing", 16'h0004, d & 16'h000f);
		// Second byte while the first request waits overruns it
		wr(sbte_pkg::ADDR_CLEAR, 16'h003f);
		sbte_peer_inst.send_byte(8'h11, 1'b1);
		sbte_peer_inst.send_byte(8'h22, 1'b1);
		repeat (4 * BIT) @(posedge clk_i);
		rd(sbte_pkg::ADDR_STATUS, d);
		chk("overrun", 16'h000c, d & 16'h000f);
		wr(sbte_pkg::ADDR_RX_DST, 16'h0010);
		wr(sbte_pkg::ADDR_RX_CNT, 16'h0001);
		repeat (10) @(posedge clk_i);
		chk_reg("rx dst one", sbte_pkg::ADDR_RX_DST, 16'h0011);
		chk_reg("rx cnt", sbte_pkg::ADDR_RX_CNT, 16'h0000);
		wr(sbte_pkg::ADDR_BUF_PTR, 16'h0110);
		chk_reg("rx last", sbte_pkg::ADDR_BUF_DATA, 16'h0022);
		chk("irq rx end", 16'h0001, {15'h0, irq_o});
		end_sim();
	end
endmodule
`default_nettype wire
